// ---- rtl/tlc_top.sv ----
// Implementation choices: the AHB-Lite slave port and the register addresses.
module tlc_top
    import tlc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // level of detail from the iterators, signed 6.2
    input wire logic lod_valid,
    input wire logic [7:0] lod_calc,
    // filter bits of texture_mode_register
    input wire logic mode_minfilter,
    input wire logic mode_magfilter,
    // per-sample result to texture memory and combine
    output logic res_valid,
    output tlc_result_t res,
    // static texture shape
    output tlc_shape_t shape,
    // incoming texture data
    input wire logic tex_in_valid,
    input wire logic [31:0] tex_in,
    output logic tex_out_valid,
    output logic [31:0] tex_out
);

    logic [31:0] lod_control_reg;
    logic [31:0] detail_texture_control_reg;
    logic [31:0] texture_base_primary_reg;
    logic [31:0] texture_base_level1_reg;
    logic [31:0] texture_base_level2_reg;
    logic [31:0] texture_base_level3_to8_reg;
    logic wr_reg;
    logic [7:0] addr_reg;
    logic take;

    function automatic logic [31:0] fix_data(input logic [31:0] d,
                                             input logic swz,
                                             input logic swp);
        logic [31:0] t;
        t = swz ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
        return swp ? {t[15:0], t[31:16]} : t;
    endfunction

    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // zero wait states: address captured, write lands in data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_reg <= 1'b0;
            addr_reg <= 8'h00;
        end
        else if (hready)
        begin
            wr_reg <= take && hwrite && (haddr[31:8] == 24'h000000);
            addr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lod_control_reg <= RESET_VAL;
            detail_texture_control_reg <= RESET_VAL;
            texture_base_primary_reg <= RESET_VAL;
            texture_base_level1_reg <= RESET_VAL;
            texture_base_level2_reg <= RESET_VAL;
            texture_base_level3_to8_reg <= RESET_VAL;
        end
        else if (wr_reg)
        begin
            if (addr_reg == OFS_LOD)
                lod_control_reg <= hwdata & MASK_LOD;
            if (addr_reg == OFS_DETAIL)
                detail_texture_control_reg <= hwdata & MASK_DETAIL;
            if (addr_reg == OFS_BASE0)
                texture_base_primary_reg <= hwdata & MASK_BASE0;
            if (addr_reg == OFS_BASE1)
                texture_base_level1_reg <= hwdata & MASK_BASEN;
            if (addr_reg == OFS_BASE2)
                texture_base_level2_reg <= hwdata & MASK_BASEN;
            if (addr_reg == OFS_BASE38)
                texture_base_level3_to8_reg <= hwdata & MASK_BASEN;
        end
    end

    // unmapped offsets read zero
    always_comb
    begin
        case (addr_reg)
            OFS_LOD: hrdata = lod_control_reg;
            OFS_DETAIL: hrdata = detail_texture_control_reg;
            OFS_BASE0: hrdata = texture_base_primary_reg;
            OFS_BASE1: hrdata = texture_base_level1_reg;
            OFS_BASE2: hrdata = texture_base_level2_reg;
            OFS_BASE38: hrdata = texture_base_level3_to8_reg;
            default: hrdata = 32'h0000_0000;
        endcase
    end

    // level-of-detail datapath
    logic [5:0] lod_min;
    logic [5:0] lod_max;
    logic [5:0] lod_bias;
    logic [5:0] lod_hi;
    logic signed [8:0] lod_sum;
    logic below_min;
    logic [5:0] lod_clamped;
    logic [3:0] level_w;
    logic multibase;
    logic [31:0] base_sel;
    logic use_min;
    logic rgb_bil_w;
    logic alpha_bil_w;
    logic [5:0] det_bias;
    logic signed [9:0] det_diff;
    logic signed [17:0] det_shift;
    logic [7:0] det_max;
    logic [7:0] det_factor_w;
    assign lod_min = lod_control_reg[LOD_MIN_LSB +: 6];
    assign lod_max = lod_control_reg[LOD_MAX_LSB +: 6];
    assign lod_bias = lod_control_reg[LOD_BIAS_LSB +: 6];
    assign multibase = lod_control_reg[MULTIBASE_BIT];
    assign det_max = detail_texture_control_reg[DET_MAX_LSB +: 8];
    assign det_bias = detail_texture_control_reg[DET_BIAS_LSB +: 6];
    always_comb
    begin
        lod_sum = $signed({lod_calc[7], lod_calc})
            + $signed({{3{lod_bias[5]}}, lod_bias});
        lod_hi = (lod_max > LOD_CEIL) ? LOD_CEIL : lod_max;
        below_min = lod_sum < $signed({3'b000, lod_min});
        if (below_min)
            lod_clamped = lod_min;
        else if (lod_sum > $signed({3'b000, lod_hi}))
            lod_clamped = lod_hi;
        else
            lod_clamped = lod_sum[5:0];
        if (lod_control_reg[ZEROFRAC_BIT])
            lod_clamped[1:0] = 2'b00;
        level_w = lod_clamped[5:2];
    end
    always_comb
    begin
        if (!multibase || level_w == 4'h0)
            base_sel = texture_base_primary_reg;
        else if (level_w == 4'h1)
            base_sel = texture_base_level1_reg;
        else if (level_w == 4'h2)
            base_sel = texture_base_level2_reg;
        else
            base_sel = texture_base_level3_to8_reg;
    end
    always_comb
    begin
        use_min = !below_min;
        rgb_bil_w = use_min ? mode_minfilter : mode_magfilter;
        alpha_bil_w = rgb_bil_w;
        if (detail_texture_control_reg[SEP_FILT_BIT])
        begin
            rgb_bil_w = use_min ? detail_texture_control_reg[RGB_MIN_BIT]
                                : detail_texture_control_reg[RGB_MAG_BIT];
            alpha_bil_w = use_min ? detail_texture_control_reg[A_MIN_BIT]
                                  : detail_texture_control_reg[A_MAG_BIT];
        end
    end
    // detail blend factor, saturated to 0.8
    always_comb
    begin
        det_diff = $signed({{4{det_bias[5]}}, det_bias})
            - $signed({6'h00, level_w});
        det_shift = $signed({{8{det_diff[9]}}, det_diff})
            <<< detail_texture_control_reg[DET_SCALE_LSB +: 3];
        if (det_shift <= $signed({10'h000, det_max}))
            det_factor_w = det_max;
        else if (det_shift > $signed(18'h000ff))
            det_factor_w = 8'hff;
        else
            det_factor_w = det_shift[7:0];
    end
    // one-cycle result stage
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            res_valid <= 1'b0;
            res <= '0;
        end
        else
        begin
            res_valid <= lod_valid;
            if (lod_valid)
            begin
                res.lod <= lod_clamped;
                res.level_index <= level_w;
                res.minify <= use_min;
                // fetch count follows these bits downstream
                res.rgb_bilinear <= rgb_bil_w;
                res.alpha_bilinear <= alpha_bil_w;
                res.detail_factor <= det_factor_w;
                res.base_addr <= base_sel[BASE_ADDR_LSB +: 20];
                res.tiled <= texture_base_primary_reg[BASE_TILED_BIT];
                res.stride <= texture_base_primary_reg[STRIDE_LSB +: 7];
            end
        end
    end

    // texture shape decode, held from the register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            shape <= '0;
        else
        begin
            shape.split <= lod_control_reg[LOD_SPLIT_BIT];
            shape.lod_odd <= lod_control_reg[LOD_ODD_BIT];
            // wider side, don't care when square
            shape.s_wider_flag <= lod_control_reg[S_WIDER_BIT];
            shape.aspect_ratio <= 4'h1 << lod_control_reg[ASPECT_LSB +: 2];
            shape.mirror_s <= lod_control_reg[MIRROR_S_BIT];
            shape.mirror_t <= lod_control_reg[MIRROR_T_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tex_out_valid <= 1'b0;
            tex_out <= 32'h0000_0000;
        end
        else
        begin
            tex_out_valid <= tex_in_valid;
            if (tex_in_valid)
                tex_out <= fix_data(tex_in, lod_control_reg[SWIZZLE_BIT],
                                    lod_control_reg[SWAP_BIT]);
        end
    end

    property p_wr_lod;
        @(posedge hclk) disable iff (!hresetn)
        wr_reg && addr_reg == OFS_LOD
            |=> lod_control_reg == ($past(hwdata) & MASK_LOD);
    endproperty
    a_wr_lod: assert property (p_wr_lod)
        else $error("lod control write not masked");
    property p_clamp_min;
        @(posedge hclk) disable iff (!hresetn)
        lod_valid && below_min && !lod_control_reg[ZEROFRAC_BIT]
            |=> res.lod == $past(lod_min) && !res.minify;
    endproperty
    a_clamp_min: assert property (p_clamp_min)
        else $error("level not clamped to minimum");
    property p_clamp_hi;
        @(posedge hclk) disable iff (!hresetn)
        res_valid && res.minify |-> res.lod <= LOD_CEIL;
    endproperty
    a_clamp_hi: assert property (p_clamp_hi)
        else $error("level above 8.0");
    property p_minify;
        @(posedge hclk) disable iff (!hresetn)
        lod_valid |=> res_valid && res.minify == !$past(below_min);
    endproperty
    a_minify: assert property (p_minify)
        else $error("wrong minify choice");
    property p_zerofrac;
        @(posedge hclk) disable iff (!hresetn)
        lod_valid && lod_control_reg[ZEROFRAC_BIT]
            |=> res.lod[1:0] == 2'b00;
    endproperty
    a_zerofrac: assert property (p_zerofrac)
        else $error("fraction not forced to zero");
    property p_swizzle_swap;
        @(posedge hclk) disable iff (!hresetn)
        tex_in_valid && lod_control_reg[SWIZZLE_BIT]
            && lod_control_reg[SWAP_BIT]
            |=> tex_out == {$past(tex_in[23:16]), $past(tex_in[31:24]),
                            $past(tex_in[7:0]), $past(tex_in[15:8])};
    endproperty
    a_swizzle_swap: assert property (p_swizzle_swap)
        else $error("byte and half swap wrong");
    property p_base0;
        @(posedge hclk) disable iff (!hresetn)
        lod_valid && !multibase
            |=> res.base_addr == $past(texture_base_primary_reg[23:4]);
    endproperty
    a_base0: assert property (p_base0)
        else $error("primary base not used");
    property p_base38;
        @(posedge hclk) disable iff (!hresetn)
        lod_valid && multibase && level_w >= 4'h3
            |=> res.base_addr == $past(texture_base_level3_to8_reg[23:4]);
    endproperty
    a_base38: assert property (p_base38)
        else $error("level 3 to 8 base not used");
    property p_shared_filter;
        @(posedge hclk) disable iff (!hresetn)
        lod_valid && !detail_texture_control_reg[SEP_FILT_BIT]
            |=> res.rgb_bilinear == res.alpha_bilinear;
    endproperty
    a_shared_filter: assert property (p_shared_filter)
        else $error("shared filter differs per channel");
    property p_detail_floor;
        @(posedge hclk) disable iff (!hresetn)
        lod_valid |=> res.detail_factor >= $past(det_max);
    endproperty
    a_detail_floor: assert property (p_detail_floor)
        else $error("detail factor below clamp");
endmodule // tlc_top

// ---- rtl/tlc_pkg.sv ----
package tlc_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_LOD = 8'h00;
    localparam logic [7:0] OFS_DETAIL = 8'h04;
    localparam logic [7:0] OFS_BASE0 = 8'h08;
    localparam logic [7:0] OFS_BASE1 = 8'h0c;
    localparam logic [7:0] OFS_BASE2 = 8'h10;
    localparam logic [7:0] OFS_BASE38 = 8'h14;

    // writable bits; everything else is reserved and reads zero
    localparam logic [31:0] MASK_LOD = 32'h37ff_ffff;
    localparam logic [31:0] MASK_DETAIL = 32'h003f_ffff;
    localparam logic [31:0] MASK_BASE0 = 32'hfeff_fff1;
    localparam logic [31:0] MASK_BASEN = 32'h00ff_fff0;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;

    // lod_control fields
    localparam int LOD_MIN_LSB = 0;
    localparam int LOD_MAX_LSB = 6;
    localparam int LOD_BIAS_LSB = 12;
    localparam int LOD_ODD_BIT = 18;
    localparam int LOD_SPLIT_BIT = 19;
    localparam int S_WIDER_BIT = 20;
    localparam int ASPECT_LSB = 21;
    localparam int ZEROFRAC_BIT = 23;
    localparam int MULTIBASE_BIT = 24;
    localparam int SWIZZLE_BIT = 25;
    localparam int SWAP_BIT = 26;
    localparam int MIRROR_S_BIT = 28;
    localparam int MIRROR_T_BIT = 29;

    // detail_texture_control fields
    localparam int DET_MAX_LSB = 0;
    localparam int DET_BIAS_LSB = 8;
    localparam int DET_SCALE_LSB = 14;
    localparam int RGB_MIN_BIT = 17;
    localparam int RGB_MAG_BIT = 18;
    localparam int A_MIN_BIT = 19;
    localparam int A_MAG_BIT = 20;
    localparam int SEP_FILT_BIT = 21;

    // base address fields
    localparam int BASE_TILED_BIT = 0;
    localparam int BASE_ADDR_LSB = 4;
    localparam int STRIDE_LSB = 25;

    // 8.0 in 4.2 fixed point
    localparam logic [5:0] LOD_CEIL = 6'h20;

    typedef struct packed {
        logic [5:0] lod;
        logic [3:0] level_index;
        logic minify;
        logic rgb_bilinear;
        logic alpha_bilinear;
        logic [7:0] detail_factor;
        logic [19:0] base_addr;
        logic tiled;
        logic [6:0] stride;
    } tlc_result_t;

    typedef struct packed {
        logic split;
        logic lod_odd;
        logic s_wider_flag;
        logic [3:0] aspect_ratio;
        logic mirror_s;
        logic mirror_t;
    } tlc_shape_t;

endpackage // tlc_pkg

// ---- testbench/tlc_far_model.sv ----
module tlc_far_model
(
    // clock
    input wire logic hclk,
    // level of detail samples and texture-mode filter bits
    output logic lod_valid,
    output logic [7:0] lod_calc,
    output logic mode_minfilter,
    output logic mode_magfilter,
    // texture words
    output logic tex_in_valid,
    output logic [31:0] tex_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        lod_valid = 1'b0;
        lod_calc = 8'h00;
        mode_minfilter = 1'b0;
        mode_magfilter = 1'b0;
        tex_in_valid = 1'b0;
        tex_in = 32'h0000_0000;
    end

    // calls in a row give one sample per cycle
    task automatic send_lod(input logic [7:0] l, input logic mn,
                            input logic mg);
        @(posedge hclk);
        lod_valid <= 1'b1;
        lod_calc <= l;
        mode_minfilter <= mn;
        mode_magfilter <= mg;
    endtask

    task automatic send_tex(input logic [31:0] w);
        @(posedge hclk);
        tex_in_valid <= 1'b1;
        tex_in <= w;
    endtask

    // released lines invert, so a stale value can never look valid
    task automatic go_idle();
        @(posedge hclk);
        lod_valid <= 1'b0;
        tex_in_valid <= 1'b0;
        lod_calc <= ~lod_calc;
        tex_in <= ~tex_in;
        mode_minfilter <= ~mode_minfilter;
        mode_magfilter <= ~mode_magfilter;
    endtask
endmodule // tlc_far_model

// ---- testbench/tb_top.sv ----
module tb_top
    import tlc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic hclk, hresetn, hsel, hwrite, hready, hresp, rd_phase;
    logic [31:0] haddr, hwdata, hrdata, tex_in, tex_out;
    logic [1:0] htrans;
    logic lod_valid, mode_minfilter, mode_magfilter, res_valid;
    logic tex_in_valid, tex_out_valid;
    logic [7:0] lod_calc;
    tlc_result_t res;
    tlc_shape_t shape;
    logic [31:0] regs [7];
    tlc_result_t exp_res [$];
    logic [31:0] exp_tex [$];
    logic [31:0] exp_rd [$];
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;

    tlc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .lod_valid(lod_valid),
        .lod_calc(lod_calc), .mode_minfilter(mode_minfilter),
        .mode_magfilter(mode_magfilter), .res_valid(res_valid),
        .res(res), .shape(shape), .tex_in_valid(tex_in_valid),
        .tex_in(tex_in), .tex_out_valid(tex_out_valid),
        .tex_out(tex_out));

    tlc_far_model i_far (.hclk(hclk), .lod_valid(lod_valid),
        .lod_calc(lod_calc), .mode_minfilter(mode_minfilter),
        .mode_magfilter(mode_magfilter), .tex_in_valid(tex_in_valid),
        .tex_in(tex_in));

    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic logic [31:0] mask_of(int i);
        case (i)
            0: return MASK_LOD;
            1: return MASK_DETAIL;
            2: return MASK_BASE0;
            3, 4, 5: return MASK_BASEN;
            default: return 32'h0000_0000;
        endcase
    endfunction

    // one transfer, held until hready; idle cycle before the next
    task automatic bus(input logic wr, input int i, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= 32'(4 * i);
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask

    task automatic wreg(input int i, input logic [31:0] d);
        bus(1'b1, i, d);
        regs[i] = d & mask_of(i);
    endtask

    task automatic rreg(input int i);
        exp_rd.push_back(regs[i]);
        bus(1'b0, i, ~hwdata);
    endtask

    function automatic tlc_result_t model(logic [7:0] lc, logic mn,
                                          logic mg);
        tlc_result_t r;
        int s, up, lo, d;
        logic sep;
        r = '0;
        lo = int'(regs[0][5:0]);
        up = (regs[0][11:6] < 6'h20) ? int'(regs[0][11:6]) : 32;
        s = int'($signed(lc)) + int'($signed(regs[0][17:12]));
        r.minify = (s >= lo);
        r.lod = !r.minify ? 6'(lo) : (s > up ? 6'(up) : 6'(s));
        if (regs[0][23])
            r.lod[1:0] = 2'b00;
        r.level_index = r.lod[5:2];
        sep = regs[1][21];
        r.rgb_bilinear = sep ? (r.minify ? regs[1][17] : regs[1][18])
                             : (r.minify ? mn : mg);
        r.alpha_bilinear = sep ? (r.minify ? regs[1][19] : regs[1][20])
                               : (r.minify ? mn : mg);
        d = int'($signed(regs[1][13:8])) - int'(r.level_index);
        d = (d < 0) ? 0 : d << regs[1][16:14];
        d = (d > 255) ? 255 : d;
        r.detail_factor = (d > int'(regs[1][7:0])) ? 8'(d) : regs[1][7:0];
        if (!regs[0][24] || r.level_index == 4'h0)
            r.base_addr = regs[2][23:4];
        else if (r.level_index == 4'h1)
            r.base_addr = regs[3][23:4];
        else if (r.level_index == 4'h2)
            r.base_addr = regs[4][23:4];
        else
            r.base_addr = regs[5][23:4];
        r.tiled = regs[2][0];
        r.stride = regs[2][31:25];
        return r;
    endfunction

    // watcher: every result takes the oldest note off its queue
    always @(posedge hclk)
    begin
        if (rd_phase && hready === 1'b1)
        begin
            if (exp_rd.size() == 0)
                check(64'(hrdata), 64'hdead);
            else
                check(64'(hrdata), 64'(exp_rd.pop_front()));
            check(64'(hresp), 64'h0);
        end
        rd_phase <= hsel && htrans[1] && !hwrite && hready;
        if (res_valid === 1'b1)
        begin
            if (exp_res.size() == 0)
                check(64'(res), 64'hdead);
            else
                check(64'(res), 64'(exp_res.pop_front()));
        end
        if (tex_out_valid === 1'b1)
        begin
            if (exp_tex.size() == 0)
                check(64'(tex_out), 64'hdead);
            else
                check(64'(tex_out), 64'(exp_tex.pop_front()));
        end
        cyc++;
        if (cyc == 6000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    initial
    begin
        logic [31:0] w, v;
        tlc_shape_t sh;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        rd_phase = 1'b0;
        for (int i = 0; i < 7; i++) regs[i] = RESET_VAL;
        void'($urandom(17));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, then all ones and random, unmapped place too
        for (int i = 0; i < 7; i++) rreg(i);
        for (int i = 0; i < 7; i++)
        begin
            wreg(i, 32'hffff_ffff);
            rreg(i);
            wreg(i, $urandom());
            rreg(i);
        end
        $display("register test done");
        // every swizzle and swap combination, back-to-back words
        for (int k = 0; k < 4; k++)
        begin
            wreg(0, {5'h00, k[1:0], 25'h0} | ($urandom() & 32'hf9ff_ffff));
            for (int n = 0; n < 4; n++)
            begin
                w = $urandom();
                v = regs[0][25] ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
                exp_tex.push_back(regs[0][26] ? {v[15:0], v[31:16]} : v);
                i_far.send_tex(w);
            end
            i_far.go_idle();
        end
        $display("texture data test done");
        for (int k = 0; k < 12; k++)
        begin
            for (int i = 0; i < 6; i++) wreg(i, $urandom());
            // first rounds: wide max so the 8.0 ceiling is reached
            if (k < 2)
                wreg(0, regs[0] | 32'h0100_0fc0);
            @(posedge hclk);
            @(posedge hclk);
            sh = {regs[0][19], regs[0][18], regs[0][20],
                  4'(4'h1 << regs[0][22:21]), regs[0][28], regs[0][29]};
            check(64'(shape), 64'(sh));
            for (int n = 0; n < 16; n++)
            begin
                w = $urandom();
                exp_res.push_back(model(w[7:0], w[8], w[9]));
                i_far.send_lod(w[7:0], w[8], w[9]);
            end
            i_far.go_idle();
        end
        $display("level of detail test done");
        repeat (4) @(posedge hclk);
        check(64'(exp_res.size() + exp_tex.size() + exp_rd.size()), 64'h0);
        end_sim();
    end
endmodule // tb_top
